// File: rtl/xcvr_consts.svh
/*
 Constants for the registered 16-bit bidirectional transceiver.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH
`define XCVR_WORD_W 16
`define XCVR_SECT_W 8
`define XCVR_DATA_RST 16'h0000
`endif

// File: rtl/xcvr_pkg.sv
/*
 Types for the registered 16-bit bidirectional transceiver.
 Assumes the constants header is available on the include path.
*/
`include "xcvr_consts.svh"
package xcvr_pkg;
	typedef logic [`XCVR_WORD_W-1:0] word_t;
	typedef logic [`XCVR_SECT_W-1:0] sect_t;
endpackage

// File: rtl/registered_bidir_transceiver16.sv
/*
 Registered 16-bit transceiver between buses A and B, one register per
 direction, each built of two 8-bit sections on shared controls.
 Assumes every pin is asynchronous to mclk; all but nrst are synchronised on
 two flip-flops, and the two direction clocks are sampled as inputs.
*/
`timescale 1ns/100ps
`include "xcvr_consts.svh"

module registered_bidir_transceiver16 (
	// System
	input wire logic mclk,
	input wire logic nrst,
	// A-to-B controls
	input wire logic a_to_b_clock,
	input wire logic a_to_b_clock_enable_n,
	input wire logic a_to_b_output_enable_n,
	// B-to-A controls
	input wire logic b_to_a_clock,
	input wire logic b_to_a_clock_enable_n,
	input wire logic b_to_a_output_enable_n,
	// A bus pins
	input wire xcvr_pkg::word_t a_in,
	input wire logic a_in_driven,
	output xcvr_pkg::word_t a_out,
	output logic a_oe,
	// B bus pins
	input wire xcvr_pkg::word_t b_in,
	input wire logic b_in_driven,
	output xcvr_pkg::word_t b_out,
	output logic b_oe
);
	// Control pins, first synchroniser stage; read only by the second
	logic [5:0] ctl_s1_r;
	// Control pins, second stage; the only copy that logic may read
	logic [5:0] ctl_s2_r;
	// Driver-presence flags: A in bit 1, B in bit 0
	logic [1:0] drv_s1_r;
	logic [1:0] drv_s2_r;
	// Data pins through the same two stages as the controls
	xcvr_pkg::word_t a_s1_r;
	xcvr_pkg::word_t a_s2_r;
	xcvr_pkg::word_t b_s1_r;
	xcvr_pkg::word_t b_s2_r;
	// Direction clock levels one cycle older, for edge detection
	logic [1:0] clk_prev_r;
	// Bus-hold keepers: last level seen while an outside driver was on
	xcvr_pkg::word_t a_hold_r;
	xcvr_pkg::word_t b_hold_r;
	// The two direction registers
	xcvr_pkg::word_t ab_r;
	xcvr_pkg::word_t ba_r;
	// Synchronised controls under readable names
	logic ab_clk;
	logic ab_ce_n;
	logic ab_oe_n;
	logic ba_clk;
	logic ba_ce_n;
	logic ba_oe_n;
	// Load strobes, one per direction, shared by both sections
	logic ab_load;
	logic ba_load;
	// Value each register would take: live pin or kept level
	xcvr_pkg::word_t ab_src;
	xcvr_pkg::word_t ba_src;

	// Load condition for one section group
	function automatic logic load_now(input logic clk_now,
		input logic clk_old, input logic ce_n);
		load_now = clk_now & ~clk_old & ~ce_n;
	endfunction

	// One 8-bit section of a word, picked by its index
	function automatic xcvr_pkg::sect_t sect_of(input xcvr_pkg::word_t w,
		input int idx);
		sect_of = w[idx*`XCVR_SECT_W +: `XCVR_SECT_W];
	endfunction

	// Bus hold: live pin while driven, otherwise the kept level
	function automatic xcvr_pkg::word_t pick_src(input xcvr_pkg::word_t live,
		input xcvr_pkg::word_t held, input logic driven);
		pick_src = driven ? live : held;
	endfunction

	// Control bit order matches the synchroniser's concatenation
	assign ab_clk = ctl_s2_r[5];
	assign ab_ce_n = ctl_s2_r[4];
	assign ab_oe_n = ctl_s2_r[3];
	assign ba_clk = ctl_s2_r[2];
	assign ba_ce_n = ctl_s2_r[1];
	assign ba_oe_n = ctl_s2_r[0];

	// Qualified rising edges; the two sections never load apart
	assign ab_load = load_now(ab_clk, clk_prev_r[1], ab_ce_n);
	assign ba_load = load_now(ba_clk, clk_prev_r[0], ba_ce_n);

	// Bus hold keeps a released input from loading a floating level
	assign ab_src = pick_src(a_s2_r, a_hold_r, drv_s2_r[1]);
	assign ba_src = pick_src(b_s2_r, b_hold_r, drv_s2_r[0]);

	// Synchronise controls
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctl_s1_r <= 6'h3f;
			ctl_s2_r <= 6'h3f;
		end else begin
			ctl_s1_r <= {a_to_b_clock, a_to_b_clock_enable_n,
				a_to_b_output_enable_n, b_to_a_clock,
				b_to_a_clock_enable_n, b_to_a_output_enable_n};
			ctl_s2_r <= ctl_s1_r;
		end
	end

	// Synchronise driver-presence flags
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			drv_s1_r <= 2'h0;
			drv_s2_r <= 2'h0;
		end else begin
			drv_s1_r <= {a_in_driven, b_in_driven};
			drv_s2_r <= drv_s1_r;
		end
	end

	// Synchronise A data; it must sit still around each load edge,
	// since the bits pass the two stages without a handshake
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			a_s1_r <= `XCVR_DATA_RST;
			a_s2_r <= `XCVR_DATA_RST;
		end else begin
			a_s1_r <= a_in;
			a_s2_r <= a_s1_r;
		end
	end

	// Synchronise B data, same stages as A
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			b_s1_r <= `XCVR_DATA_RST;
			b_s2_r <= `XCVR_DATA_RST;
		end else begin
			b_s1_r <= b_in;
			b_s2_r <= b_s1_r;
		end
	end

	// Previous clock levels for rising-edge detection
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clk_prev_r <= 2'h3; // No false edge out of reset
		end else begin
			clk_prev_r <= {ctl_s2_r[5], ctl_s2_r[2]};
		end
	end

	// A bus keeper: follows the pin only while an outside driver is on
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			a_hold_r <= `XCVR_DATA_RST;
		end else if (drv_s2_r[1]) begin
			a_hold_r <= a_s2_r;
		end
	end

	// B bus keeper, same as A
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			b_hold_r <= `XCVR_DATA_RST;
		end else if (drv_s2_r[0]) begin
			b_hold_r <= b_s2_r;
		end
	end

	// A-to-B register; both sections take the same strobe, so one word.
	// Reset value is only a simulation convenience: real contents undefined.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ab_r <= `XCVR_DATA_RST;
		end else begin
			for (int s = 0; s < `XCVR_WORD_W / `XCVR_SECT_W; s++) begin
				if (ab_load) begin
					ab_r[s*`XCVR_SECT_W +: `XCVR_SECT_W] <=
						sect_of(ab_src, s);
				end
			end
		end
	end

	// B-to-A register, the mirror of the one above on its own controls
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ba_r <= `XCVR_DATA_RST;
		end else begin
			for (int s = 0; s < `XCVR_WORD_W / `XCVR_SECT_W; s++) begin
				if (ba_load) begin
					ba_r[s*`XCVR_SECT_W +: `XCVR_SECT_W] <=
						sect_of(ba_src, s);
				end
			end
		end
	end

	// B pin drivers, registered so outputs come straight from flip-flops;
	// the enable thus reaches the pin three mclk edges after its own pin
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			b_out <= `XCVR_DATA_RST;
			b_oe <= 1'b0; // Pins float while in reset
		end else begin
			b_out <= ab_r;
			b_oe <= ~ab_oe_n;
		end
	end

	// A pin drivers, mirror of the B side
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			a_out <= `XCVR_DATA_RST;
			a_oe <= 1'b0;
		end else begin
			a_out <= ba_r;
			a_oe <= ~ba_oe_n;
		end
	end
endmodule

// File: tb/xcvr_asserts.sv
/* Port checker for the registered transceiver.
 Assumes a bind to the top module, mclk its only clock. */
`timescale 1ns/100ps
module xcvr_asserts (
	// Clock, reset and controls
	input wire logic mclk, nrst,
	input wire logic a_to_b_clock, a_to_b_clock_enable_n,
	input wire logic a_to_b_output_enable_n, b_to_a_clock,
	input wire logic b_to_a_clock_enable_n, b_to_a_output_enable_n,
	// Bus pins
	input wire xcvr_pkg::word_t a_in, b_in, a_out, b_out,
	input wire logic a_in_driven, b_in_driven, a_oe, b_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Pins seen on the same edges as the first sync stage: exact latency
	a_ab_load: assert property ($rose(a_to_b_clock) &&
		!a_to_b_clock_enable_n && a_in_driven |->
		##4 b_out == $past(a_in, 4)) else $error("b_out load");
	a_ba_load: assert property ($rose(b_to_a_clock) &&
		!b_to_a_clock_enable_n && b_in_driven |->
		##4 a_out == $past(b_in, 4)) else $error("a_out load");
	a_ab_hold: assert property (a_to_b_clock_enable_n[*6] |->
		$stable(b_out)) else $error("b_out moved");
	a_ba_hold: assert property (b_to_a_clock_enable_n[*6] |->
		$stable(a_out)) else $error("a_out moved");
	a_ab_drive: assert property (!a_to_b_output_enable_n[*5] |->
		b_oe) else $error("b_oe low");
	a_ab_float: assert property (a_to_b_output_enable_n[*5] |->
		!b_oe) else $error("b_oe high");
	a_ba_drive: assert property (!b_to_a_output_enable_n[*5] |->
		a_oe) else $error("a_oe low");
	a_ba_float: assert property (b_to_a_output_enable_n[*5] |->
		!a_oe) else $error("a_oe high");
	// Main scenarios reached
	c_b_drive: cover property ($rose(b_oe));
	c_a_drive: cover property ($rose(a_oe));
	c_b_load: cover property ($changed(b_out));
endmodule

// File: tb/bus_side.sv
/* Outside driver of one data bus and the resolved wire.
 Assumes the bench releases it while the device drives. */
`timescale 1ns/100ps
module bus_side (
	// Clock
	input wire logic mclk,
	// Outside driver and device side
	input wire xcvr_pkg::word_t val, dev_out,
	input wire logic en, dev_oe,
	// Resolved wire
	output xcvr_pkg::word_t pin,
	output logic driven
);
	xcvr_pkg::word_t last_r = 16'h0000;
	// Released wire toggles, so a stale value cannot pass
	always @(posedge mclk) last_r <= pin;
	assign pin = dev_oe ? dev_out : en ? val : ~last_r;
	assign driven = en;
endmodule

// File: tb/test_registered_bidir_transceiver16.sv
/* Self-checking bench of the registered transceiver.
 Assumes the package and the partner model compile first. */
`timescale 1ns/100ps
module test_registered_bidir_transceiver16;
	logic mclk = 0, nrst = 0, ae = 1, be = 1;
	logic a_to_b_clock = 0, a_to_b_clock_enable_n = 0;
	logic a_to_b_output_enable_n = 1, b_to_a_clock = 0;
	logic b_to_a_clock_enable_n = 0, b_to_a_output_enable_n = 1;
	logic a_in_driven, b_in_driven, a_oe, b_oe;
	xcvr_pkg::word_t av = 16'h0000, bv = 16'h0000;
	xcvr_pkg::word_t a_in, b_in, a_out, b_out;
	int err_total = 0, n_tests = 0;
	always #5 mclk = ~mclk;
	registered_bidir_transceiver16 registered_bidir_transceiver16_inst (
		.mclk(mclk), .nrst(nrst),
		.a_to_b_clock(a_to_b_clock),
		.a_to_b_clock_enable_n(a_to_b_clock_enable_n),
		.a_to_b_output_enable_n(a_to_b_output_enable_n),
		.b_to_a_clock(b_to_a_clock),
		.b_to_a_clock_enable_n(b_to_a_clock_enable_n),
		.b_to_a_output_enable_n(b_to_a_output_enable_n),
		.a_in(a_in), .a_in_driven(a_in_driven), .a_out(a_out), .a_oe(a_oe),
		.b_in(b_in), .b_in_driven(b_in_driven), .b_out(b_out), .b_oe(b_oe));
	bus_side a_side_inst (.mclk(mclk), .val(av), .dev_out(a_out),
		.en(ae), .dev_oe(a_oe), .pin(a_in), .driven(a_in_driven));
	bus_side b_side_inst (.mclk(mclk), .val(bv), .dev_out(b_out),
		.en(be), .dev_oe(b_oe), .pin(b_in), .driven(b_in_driven));
	task chk(input xcvr_pkg::word_t got, exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %h %h", $time, got, exp);
		end
	endtask
	task chk_oe(input logic [1:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %h %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Outputs off before drivers on, so the buses never fight
	task xfer(input xcvr_pkg::word_t va, vb, input logic ce_n, rel);
		a_to_b_output_enable_n = 1;
		b_to_a_output_enable_n = 1;
		step(5);
		chk_oe({a_oe, b_oe}, 2'h0);
		{av, bv, ae, be} = {va, vb, 2'b11};
		{a_to_b_clock_enable_n, b_to_a_clock_enable_n} = {ce_n, ce_n};
		step(4);
		{ae, be} = {!rel, !rel};
		step(4);
		{a_to_b_clock, b_to_a_clock} = 2'b11;
		step(4);
		{a_to_b_clock, b_to_a_clock, ae, be} = 4'h0;
		step(4);
		{a_to_b_output_enable_n, b_to_a_output_enable_n} = 2'b00;
		step(6);
		chk_oe({a_oe, b_oe}, 2'h3);
	endtask
	task s_load;
		xfer(16'hA5C3, 16'h3C5A, 0, 0);
		chk(b_out, 16'hA5C3);
		chk(a_out, 16'h3C5A);
	endtask
	task s_refuse;
		xfer(16'h0FF0, 16'hF00F, 1, 0);
		chk(b_out, 16'hA5C3);
		chk(a_out, 16'h3C5A);
	endtask
	task s_hold;
		xfer(16'h8001, 16'h7FFE, 0, 1);
		chk(b_out, 16'h8001);
		chk(a_out, 16'h7FFE);
	endtask
	task print_verdict;
		if (err_total == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Reset for 3 cycles, then the scenarios
	initial begin
		step(3);
		nrst = 1;
		step(3);
		s_load;
		s_refuse;
		s_hold;
		print_verdict;
	end
endmodule
bind registered_bidir_transceiver16 xcvr_asserts xcvr_asserts_inst (
	.mclk(mclk), .nrst(nrst),
	.a_to_b_clock(a_to_b_clock),
	.a_to_b_clock_enable_n(a_to_b_clock_enable_n),
	.a_to_b_output_enable_n(a_to_b_output_enable_n),
	.b_to_a_clock(b_to_a_clock),
	.b_to_a_clock_enable_n(b_to_a_clock_enable_n),
	.b_to_a_output_enable_n(b_to_a_output_enable_n),
	.a_in(a_in), .b_in(b_in), .a_out(a_out), .b_out(b_out),
	.a_in_driven(a_in_driven), .b_in_driven(b_in_driven),
	.a_oe(a_oe), .b_oe(b_oe));
